/* bench/mcod_decoder_assertions.sv */
// ==========================================
// port checker
module mcod_decoder_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] modrm_i,
  input wire logic [5:0] operation_o,
  input wire logic decoded_o,
  input wire logic invalid_o,
  input wire logic memory_operand_o,
  input wire logic [2:0] operand_format_o,
  input wire logic [2:0] stack_register_index_o,
  input wire logic direction_o,
  input wire logic pop_o,
  input wire logic reverse_o,
  input wire logic state_change_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcod_pkg::*;
  logic esc, rf, arith, rs, db, pb;
  logic [1:0] mf;
  logic [2:0] idx;
  assign esc = valid_i && opcode_i[7:3] == 5'h1b;
  assign rf = modrm_i[7:6] == 2'h3;
  assign arith = esc && !opcode_i[0] && rf && (modrm_i[5] || !modrm_i[4]);
  assign rs = modrm_i[3] ^ opcode_i[2];
  assign db = opcode_i[2];
  assign pb = opcode_i[1];
  assign mf = opcode_i[2:1];
  assign idx = modrm_i[2:0];
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence lone_s;
    esc ##1 !esc;
  endsequence
  esc_answer_a: assert property (esc |=> decoded_o ^ invalid_o)
    else $error("escape not answered");
  pulse_one_a: assert property (lone_s |=> !decoded_o && !invalid_o)
    else $error("pulse too long");
  hold_out_a: assert property (!esc |=> $stable(operation_o))
    else $error("output moved without escape");
  index_flag_a: assert property (esc |=> stack_register_index_o ==
    ($past(rf) ? $past(idx) : 3'h0) && memory_operand_o == !$past(rf))
    else $error("index or memory flag wrong");
  invalid_quiet_a: assert property (invalid_o |->
    operation_o == MCOD_OP_INVALID && !state_change_o && !pop_o)
    else $error("invalid changes state");
  const_load_a: assert property (esc && opcode_i[2:0] == 3'h1
    && modrm_i[7:3] == 5'h1d && idx != 3'h7
    |=> operation_o == 6'h0a + $past(idx))
    else $error("constant load wrong");
  arith_dir_a: assert property (arith |=> direction_o == $past(db)
    && pop_o == $past(pb))
    else $error("direction or pop wrong");
  arith_rev_a: assert property (arith && modrm_i[5]
    |=> reverse_o == $past(rs))
    else $error("reverse sense wrong");
  mem_fmt_a: assert property (esc && !rf && !opcode_i[0]
    |=> operand_format_o == {1'b0, $past(mf)})
    else $error("memory format wrong");
  nop_quiet_a: assert property (esc && opcode_i[2:0] == 3'h1
    && modrm_i == 8'hd0 |=> decoded_o && !state_change_o)
    else $error("no-op changed state");
endmodule : mcod_decoder_checker

bind mcod_decoder mcod_decoder_checker mcod_decoder_checker_inst (
  .clock_i(clock_i), .resetn_i(resetn_i), .valid_i(valid_i),
  .opcode_i(opcode_i), .modrm_i(modrm_i), .operation_o(operation_o),
  .decoded_o(decoded_o), .invalid_o(invalid_o),
  .memory_operand_o(memory_operand_o),
  .operand_format_o(operand_format_o),
  .stack_register_index_o(stack_register_index_o),
  .direction_o(direction_o), .pop_o(pop_o), .reverse_o(reverse_o),
  .state_change_o(state_change_o));

/* bench/mcod_decoder_tb_top.sv */
module mcod_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mcod_pkg::*;
  logic clock_i, resetn_i, valid_i;
  logic [7:0] opcode_i, modrm_i;
  mcod_op_t operation_o;
  logic decoded_o, invalid_o, memory_operand_o, direction_o;
  logic pop_o, reverse_o, state_change_o;
  logic [2:0] operand_format_o, stack_register_index_o;
  logic [18:0] seen_v;
  logic [31:0] q[$];
  int fails, n_tests;
  assign seen_v = {operation_o, decoded_o, invalid_o, state_change_o,
    operand_format_o, direction_o, pop_o, reverse_o, memory_operand_o,
    stack_register_index_o};
  mcod_host_model mcod_host_model_inst (.clock_i(clock_i),
    .valid_o(valid_i), .opcode_o(opcode_i), .modrm_o(modrm_i));
  mcod_decoder mcod_decoder_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .valid_i(valid_i), .opcode_i(opcode_i), .modrm_i(modrm_i),
    .operation_o(operation_o), .decoded_o(decoded_o),
    .invalid_o(invalid_o), .memory_operand_o(memory_operand_o),
    .operand_format_o(operand_format_o),
    .stack_register_index_o(stack_register_index_o),
    .direction_o(direction_o), .pop_o(pop_o), .reverse_o(reverse_o),
    .state_change_o(state_change_o));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // ==========================================
  // table entry: opcode, modrm, operation, {format, dir, pop, rev}
  // expected output word for one table entry, in the order of seen_v
  function automatic logic [18:0] exp_vec(input logic [31:0] e);
    logic [5:0] op;
    logic [7:0] rm;
    op = e[13:8];
    rm = e[23:16];
    exp_vec = {op, op != MCOD_OP_INVALID, op == MCOD_OP_INVALID,
      op != MCOD_OP_INVALID && op != MCOD_OP_NOP, e[5:0],
      rm[7:6] != 2'h3, rm[7:6] == 2'h3 ? rm[2:0] : 3'h0};
  endfunction : exp_vec
  task automatic run_q();
    foreach (q[k]) begin
      mcod_host_model_inst.issue(q[k][31:24], q[k][23:16], 1'b1);
      mcod_host_model_inst.rest();
      #1;
      check(32'(seen_v), 32'(exp_vec(q[k])));
    end
  endtask : run_q
  // random bytes, half forced to escape, some with valid low
  task automatic rand_run();
    logic [7:0] b, r;
    logic v;
    mcod_op_t keep;
    for (int k = 0; k < 400; k++) begin
      b = 8'($urandom());
      r = 8'($urandom());
      v = (k % 5) != 0;
      if (k[0])
        b = {5'h1b, b[2:0]};
      keep = operation_o;
      mcod_host_model_inst.issue(b, r, v);
      mcod_host_model_inst.rest();
      #1;
      if (v && b[7:3] == 5'h1b)
        check(32'({memory_operand_o, decoded_o ^ invalid_o}),
          32'({r[7:6] != 2'h3, 1'b1}));
      else
        check(32'({operation_o, decoded_o, invalid_o}),
          32'({keep, 2'b00}));
    end
  endtask : rand_run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    fails = 0;
    n_tests = 0;
    resetn_i = 1'b0;
    void'($urandom(32'hff91));
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    q = '{32'hd9e80a00, 32'hd9e90b00, 32'hd9ea0c00, 32'hd9eb0d00,
      32'hd9ec0e00, 32'hd9ed0f00, 32'hd9ee1000};
    run_q();
    q = '{32'hd9e01b00, 32'hd9e11a00, 32'hd9e40800, 32'hd9e50900};
    run_q();
    q = '{32'hd9f81700, 32'hd9f92000, 32'hd9fa1500, 32'hd9fc1800,
      32'hd9fd1600, 32'hd9f01e00, 32'hd9f11f00, 32'hd9f21c00,
      32'hd9f31d00, 32'hd9f41900, 32'hd9f62d00, 32'hd9f72c00};
    run_q();
    q = '{32'hdbe22700, 32'hdbe32100, 32'hdbe42200, 32'hdfe02300};
    run_q();
    q = '{32'hd9282400, 32'hd9382500, 32'hd9202900, 32'hd9302800,
      32'hdd382600, 32'hdd302a00, 32'hdd202b00};
    run_q();
    q = '{32'hddc32e00, 32'hd9d02f00, 32'hd9cd0400, 32'hded90702};
    run_q();
    q = '{32'hdf280120, 32'hdb280128, 32'hdf200130, 32'hd9100200,
      32'hdb18030a, 32'hdd500210, 32'hdf18031a};
    run_q();
    q = '{32'hd8001100, 32'hda081308, 32'hdc201210, 32'hde281219,
      32'hd8301400, 32'hd8381401};
    run_q();
    q = '{32'hd8c11100, 32'hdcc91304, 32'hdee11207, 32'hd8e91201,
      32'hdcf91404, 32'hdef11407, 32'hdac11102};
    run_q();
    q = '{32'hd9d10000, 32'hd9e20000, 32'hdbe00000, 32'hdde00000,
      32'hd9080000, 32'hd9d80000};
    run_q();
    $display("test table done");
    mcod_host_model_inst.issue(8'hd9, 8'he8, 1'b1);
    mcod_host_model_inst.issue(8'hd9, 8'hee, 1'b1);
    #1;
    check(32'(operation_o), 32'(MCOD_OP_LOAD_ONE));
    mcod_host_model_inst.rest();
    #1;
    check(32'(operation_o), 32'(MCOD_OP_LOAD_ZERO));
    $display("test back_to_back done");
    rand_run();
    $display("test random done");
    @(posedge clock_i);
    resetn_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(32'(seen_v), 32'h0);
    @(posedge clock_i);
    resetn_i <= 1'b1;
    q = '{32'hd9e80a00};
    run_q();
    $display("test reset done");
    test_done();
  end
endmodule : mcod_decoder_tb_top

/* bench/mcod_host_model.sv */
// ==========================================
// host side: hands over one escape per call
module mcod_host_model (
  input wire logic clock_i,
  output logic valid_o,
  output logic [7:0] opcode_o,
  output logic [7:0] modrm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid_o = 1'b0;
    opcode_o = 8'h00;
    modrm_o = 8'h00;
  end
  // both bytes travel together in one cycle
  task automatic issue(input logic [7:0] op, input logic [7:0] rm,
    input logic v);
    @(posedge clock_i);
    valid_o <= v;
    opcode_o <= op;
    modrm_o <= rm;
  endtask : issue
  // released bytes are inverted so stale values never look valid
  task automatic rest();
    @(posedge clock_i);
    valid_o <= 1'b0;
    opcode_o <= ~opcode_o;
    modrm_o <= ~modrm_o;
  endtask : rest
endmodule : mcod_host_model

/* rtl/mcod_decoder.sv */
`include "mcod_map.svh"

// Function
// - reverse 0 is dest op src, 1 src op dest; inverted when direction is 1
// - escape when opcode bits 7:3 equal 11011; bits 2:0 secondary field
// - memory format 00 real32, 01 int32, 10 real64, 11 int16
// - direction 0 writes stack top, 1 writes selected lower register
// - pop 0 leaves stack alone, 1 pops stack top after operation
// - memory format,1 with reg 010 stores stack top; 011 stores and pops
// - memory format,0 is memory arithmetic: 000 add, 001 mul, 10R sub, 11R div
// - register arithmetic d,P,0 with 11000 add, 11001 mul, 1110R sub, 1111R div
// - secondary 001 byte 11101xxx loads constants one through zero
// - secondary 001 byte 11100000 negates, 11100001 takes absolute value
// - secondary 001 byte 11100100 tests, 11100101 examines stack top
// - secondary 001 byte 11111xxx remainder, yl2xp1, sqrt, round, scale
// - secondary 001 byte 11110xxx transcendental, extract, stack pointer steps
// - secondary 011 byte 111000xx: 10 clear, 11 init; 11100100 protected mode
// - secondary 111 byte 11100000 stores status word to accumulator
// - secondary 001 memory reg 101/111 control word, 100/110 environment
// - secondary 101 memory reg 111 store status, 110 save, 100 restore
// - secondary 101 byte 11000iii marks stack register iii free
// - secondary 001 byte 11010000 is a no-operation
// - secondary 001 byte 11001iii swaps stack top with register iii
// - secondary 110 byte 11011001 compares and pops twice
// - memory loads: 111/101 long int, 011/101 temp real, 111/100 packed
module mcod_decoder (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] modrm_i,
  output mcod_pkg::mcod_op_t operation_o,
  output logic decoded_o,
  output logic invalid_o,
  output logic memory_operand_o,
  output logic [2:0] operand_format_o,
  output logic [2:0] stack_register_index_o,
  output logic direction_o,
  output logic pop_o,
  output logic reverse_o,
  output logic state_change_o
);
  import mcod_pkg::*;

  // ===================================================================
  // field extraction
  logic is_escape;
  logic [2:0] secondary;
  logic [1:0] memory_format_field;
  logic [2:0] reg_field;
  logic is_mem;

  assign is_escape = (opcode_i[`MCOD_ESC_HI:`MCOD_ESC_LO] == `MCOD_ESC_PATTERN);
  assign secondary = opcode_i[2:0];
  assign memory_format_field = opcode_i[2:1];
  assign reg_field = modrm_i[`MCOD_MODRM_REG_HI:`MCOD_MODRM_REG_LO];
  assign is_mem = (modrm_i[7:6] != `MCOD_MOD_REGISTER);

  // the memory format maps onto the low codes of the format output
  function automatic logic [2:0] mf_to_format(input logic [1:0] mf);
    case (mf)
      `MCOD_MF_REAL32: mf_to_format = 3'h0;
      `MCOD_MF_INT32: mf_to_format = 3'h1;
      `MCOD_MF_REAL64: mf_to_format = 3'h2;
      default: mf_to_format = 3'h3;
    endcase
  endfunction : mf_to_format

  // ===================================================================
  // decode
  mcod_op_t next_operation;
  logic next_decoded;
  logic next_invalid;
  logic next_memory_operand;
  logic [2:0] next_operand_format;
  logic [2:0] next_stack_register_index;
  logic next_direction;
  logic next_pop;
  logic next_reverse;
  logic next_state_change;
  mcod_op_t op;
  logic dir;
  logic pop;
  logic rev;
  logic [2:0] fmt;

  always_comb begin
    op = MCOD_OP_INVALID;
    dir = 1'b0;
    pop = 1'b0;
    rev = 1'b0;
    fmt = `MCOD_FMT_NONE;
    if (is_mem) begin
      fmt = mf_to_format(memory_format_field);
      if (secondary[0]) begin
        case (reg_field)
          3'h0: op = MCOD_OP_LOAD;
          3'h2: op = MCOD_OP_STORE;
          3'h3: begin
            op = MCOD_OP_STORE_POP;
            pop = 1'b1;
          end
          default: op = MCOD_OP_INVALID;
        endcase
        case (secondary)
          3'h1: begin
            fmt = `MCOD_FMT_NONE;
            case (reg_field)
              3'h4: op = MCOD_OP_LOAD_ENV;
              3'h5: op = MCOD_OP_LOAD_CW;
              3'h6: op = MCOD_OP_STORE_ENV;
              3'h7: op = MCOD_OP_STORE_CW;
              default: ;
            endcase
          end
          3'h3: begin
            if (reg_field == 3'h5) begin
              op = MCOD_OP_LOAD;
              fmt = `MCOD_FMT_TEMP_REAL;
            end else if (reg_field == 3'h7) begin
              op = MCOD_OP_STORE_POP;
              pop = 1'b1;
              fmt = `MCOD_FMT_TEMP_REAL;
            end
          end
          3'h5: begin
            fmt = reg_field[2] ? `MCOD_FMT_NONE : fmt;
            case (reg_field)
              3'h4: op = MCOD_OP_RESTORE;
              3'h6: op = MCOD_OP_SAVE;
              3'h7: op = MCOD_OP_STORE_SW;
              default: ;
            endcase
          end
          3'h7: begin
            case (reg_field)
              3'h4: begin
                op = MCOD_OP_LOAD;
                fmt = `MCOD_FMT_PACKED_BCD;
              end
              3'h5: begin
                op = MCOD_OP_LOAD;
                fmt = `MCOD_FMT_LONG_INT;
              end
              3'h6: begin
                op = MCOD_OP_STORE_POP;
                pop = 1'b1;
                fmt = `MCOD_FMT_PACKED_BCD;
              end
              3'h7: begin
                op = MCOD_OP_STORE_POP;
                pop = 1'b1;
                fmt = `MCOD_FMT_LONG_INT;
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end else begin
        case (reg_field)
          3'h0: op = MCOD_OP_ADD;
          3'h1: op = MCOD_OP_MUL;
          3'h2: op = MCOD_OP_COMPARE;
          3'h3: begin
            op = MCOD_OP_COMPARE_POP;
            pop = 1'b1;
          end
          3'h4, 3'h5: op = MCOD_OP_SUB;
          default: op = MCOD_OP_DIV;
        endcase
        rev = reg_field[2] & reg_field[0];
      end
    end else if (!secondary[0]) begin
      // register arithmetic: direction and pop sit in bits 2:1
      dir = secondary[2];
      pop = secondary[1];
      rev = modrm_i[5] & (modrm_i[3] ^ secondary[2]);
      case (modrm_i[5:3])
        3'h0: op = MCOD_OP_ADD;
        3'h1: op = MCOD_OP_MUL;
        3'h4, 3'h5: op = MCOD_OP_SUB;
        3'h6, 3'h7: op = MCOD_OP_DIV;
        default: op = MCOD_OP_INVALID;
      endcase
      if (secondary == 3'h0 && modrm_i[5:4] == 2'h1) begin
        op = modrm_i[3] ? MCOD_OP_COMPARE_POP : MCOD_OP_COMPARE;
        pop = modrm_i[3];
      end
      if (secondary == 3'h6 && modrm_i == `MCOD_B2_CMP_PP) begin
        op = MCOD_OP_COMPARE_DOUBLE_POP;
        pop = 1'b1;
        dir = 1'b0;
      end
    end else begin
      case (secondary)
        3'h1: begin
          case (modrm_i[5:3])
            3'h0: op = MCOD_OP_LOAD;
            3'h1: op = MCOD_OP_SWAP;
            3'h2: op = (modrm_i == `MCOD_B2_NOP) ?
                       MCOD_OP_NOP : MCOD_OP_INVALID;
            3'h4: begin
              case (modrm_i)
                `MCOD_B2_CHS: op = MCOD_OP_NEGATE;
                `MCOD_B2_ABS: op = MCOD_OP_ABS;
                `MCOD_B2_TEST: op = MCOD_OP_TEST;
                `MCOD_B2_EXAMINE: op = MCOD_OP_EXAMINE;
                default: op = MCOD_OP_INVALID;
              endcase
            end
            3'h5: begin
              case (modrm_i[2:0])
                3'h0: op = MCOD_OP_LOAD_ONE;
                3'h1: op = MCOD_OP_LOAD_LOG2_TEN;
                3'h2: op = MCOD_OP_LOAD_LOG2_E;
                3'h3: op = MCOD_OP_LOAD_PI;
                3'h4: op = MCOD_OP_LOAD_LOG10_TWO;
                3'h5: op = MCOD_OP_LOAD_LN_TWO;
                3'h6: op = MCOD_OP_LOAD_ZERO;
                default: op = MCOD_OP_INVALID;
              endcase
            end
            3'h6: begin
              case (modrm_i[2:0])
                3'h0: op = MCOD_OP_TWO_POW_M1;
                3'h1: op = MCOD_OP_YL2X;
                3'h2: op = MCOD_OP_PTAN;
                3'h3: op = MCOD_OP_PATAN;
                3'h4: op = MCOD_OP_EXTRACT;
                3'h6: op = MCOD_OP_DEC_SP;
                3'h7: op = MCOD_OP_INC_SP;
                default: op = MCOD_OP_INVALID;
              endcase
            end
            3'h7: begin
              case (modrm_i[2:0])
                3'h0: op = MCOD_OP_PREM;
                3'h1: op = MCOD_OP_YL2XP1;
                3'h2: op = MCOD_OP_SQRT;
                3'h4: op = MCOD_OP_ROUND;
                3'h5: op = MCOD_OP_SCALE;
                default: op = MCOD_OP_INVALID;
              endcase
            end
            default: op = MCOD_OP_INVALID;
          endcase
        end
        3'h3: begin
          case (modrm_i)
            `MCOD_B2_CLEX: op = MCOD_OP_CLEX;
            `MCOD_B2_INIT: op = MCOD_OP_INIT;
            `MCOD_B2_SETPM: op = MCOD_OP_SETPM;
            default: op = MCOD_OP_INVALID;
          endcase
        end
        3'h5: begin
          case (modrm_i[5:3])
            3'h0: op = MCOD_OP_FREE;
            3'h2: op = MCOD_OP_STORE;
            3'h3: begin
              op = MCOD_OP_STORE_POP;
              pop = 1'b1;
            end
            default: op = MCOD_OP_INVALID;
          endcase
        end
        default: begin
          op = (modrm_i == `MCOD_B2_STSW_AX) ?
               MCOD_OP_STSW_ACC : MCOD_OP_INVALID;
        end
      endcase
    end
    if (op == MCOD_OP_INVALID) begin
      dir = 1'b0;
      pop = 1'b0;
      rev = 1'b0;
      fmt = `MCOD_FMT_NONE;
    end
  end

  always_comb begin
    next_operation = operation_o;
    next_decoded = 1'b0;
    next_invalid = 1'b0;
    next_memory_operand = memory_operand_o;
    next_operand_format = operand_format_o;
    next_stack_register_index = stack_register_index_o;
    next_direction = direction_o;
    next_pop = pop_o;
    next_reverse = reverse_o;
    next_state_change = 1'b0;
    if (valid_i && is_escape) begin
      next_operation = op;
      next_decoded = (op != MCOD_OP_INVALID);
      next_invalid = (op == MCOD_OP_INVALID);
      next_memory_operand = is_mem;
      next_operand_format = fmt;
      next_stack_register_index = is_mem ? 3'h0 : modrm_i[2:0];
      next_direction = dir;
      next_pop = pop;
      next_reverse = rev;
      // invalid and no-op leave stack and control state untouched
      next_state_change = (op != MCOD_OP_INVALID) &&
                          (op != MCOD_OP_NOP);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      operation_o <= MCOD_OP_INVALID;
      decoded_o <= 1'b0;
      invalid_o <= 1'b0;
      memory_operand_o <= 1'b0;
      operand_format_o <= `MCOD_FMT_NONE;
      stack_register_index_o <= 3'h0;
      direction_o <= 1'b0;
      pop_o <= 1'b0;
      reverse_o <= 1'b0;
      state_change_o <= 1'b0;
    end else begin
      operation_o <= next_operation;
      decoded_o <= next_decoded;
      invalid_o <= next_invalid;
      memory_operand_o <= next_memory_operand;
      operand_format_o <= next_operand_format;
      stack_register_index_o <= next_stack_register_index;
      direction_o <= next_direction;
      pop_o <= next_pop;
      reverse_o <= next_reverse;
      state_change_o <= next_state_change;
    end
  end

endmodule : mcod_decoder

/* rtl/mcod_map.svh */
`ifndef MCOD_MAP_SVH
`define MCOD_MAP_SVH

// =====================================================================
// escape recognition and field positions
`define MCOD_ESC_PATTERN 5'h1b
`define MCOD_ESC_HI 7
`define MCOD_ESC_LO 3
`define MCOD_MODRM_REG_HI 5
`define MCOD_MODRM_REG_LO 3
`define MCOD_MOD_REGISTER 2'h3

// =====================================================================
// memory format codes
`define MCOD_MF_REAL32 2'h0
`define MCOD_MF_INT32 2'h1
`define MCOD_MF_REAL64 2'h2
`define MCOD_MF_INT16 2'h3

// =====================================================================
// operand format codes driven on the format output
`define MCOD_FMT_NONE 3'h0
`define MCOD_FMT_LONG_INT 3'h4
`define MCOD_FMT_TEMP_REAL 3'h5
`define MCOD_FMT_PACKED_BCD 3'h6

// =====================================================================
// second byte patterns for register forms
`define MCOD_B2_TEST 8'he4
`define MCOD_B2_EXAMINE 8'he5
`define MCOD_B2_NOP 8'hd0
`define MCOD_B2_STSW_AX 8'he0
`define MCOD_B2_CMP_PP 8'hd9
`define MCOD_B2_CHS 8'he0
`define MCOD_B2_ABS 8'he1
`define MCOD_B2_CLEX 8'he2
`define MCOD_B2_INIT 8'he3
`define MCOD_B2_SETPM 8'he4

`endif

/* rtl/mcod_pkg.sv */
package mcod_pkg;

  typedef enum logic [5:0] {
    MCOD_OP_INVALID = 6'h00,
    MCOD_OP_LOAD = 6'h01,
    MCOD_OP_STORE = 6'h02,
    MCOD_OP_STORE_POP = 6'h03,
    MCOD_OP_SWAP = 6'h04,
    MCOD_OP_COMPARE = 6'h05,
    MCOD_OP_COMPARE_POP = 6'h06,
    MCOD_OP_COMPARE_DOUBLE_POP = 6'h07,
    MCOD_OP_TEST = 6'h08,
    MCOD_OP_EXAMINE = 6'h09,
    MCOD_OP_LOAD_ONE = 6'h0a,
    MCOD_OP_LOAD_LOG2_TEN = 6'h0b,
    MCOD_OP_LOAD_LOG2_E = 6'h0c,
    MCOD_OP_LOAD_PI = 6'h0d,
    MCOD_OP_LOAD_LOG10_TWO = 6'h0e,
    MCOD_OP_LOAD_LN_TWO = 6'h0f,
    MCOD_OP_LOAD_ZERO = 6'h10,
    MCOD_OP_ADD = 6'h11,
    MCOD_OP_SUB = 6'h12,
    MCOD_OP_MUL = 6'h13,
    MCOD_OP_DIV = 6'h14,
    MCOD_OP_SQRT = 6'h15,
    MCOD_OP_SCALE = 6'h16,
    MCOD_OP_PREM = 6'h17,
    MCOD_OP_ROUND = 6'h18,
    MCOD_OP_EXTRACT = 6'h19,
    MCOD_OP_ABS = 6'h1a,
    MCOD_OP_NEGATE = 6'h1b,
    MCOD_OP_PTAN = 6'h1c,
    MCOD_OP_PATAN = 6'h1d,
    MCOD_OP_TWO_POW_M1 = 6'h1e,
    MCOD_OP_YL2X = 6'h1f,
    MCOD_OP_YL2XP1 = 6'h20,
    MCOD_OP_INIT = 6'h21,
    MCOD_OP_SETPM = 6'h22,
    MCOD_OP_STSW_ACC = 6'h23,
    MCOD_OP_LOAD_CW = 6'h24,
    MCOD_OP_STORE_CW = 6'h25,
    MCOD_OP_STORE_SW = 6'h26,
    MCOD_OP_CLEX = 6'h27,
    MCOD_OP_STORE_ENV = 6'h28,
    MCOD_OP_LOAD_ENV = 6'h29,
    MCOD_OP_SAVE = 6'h2a,
    MCOD_OP_RESTORE = 6'h2b,
    MCOD_OP_INC_SP = 6'h2c,
    MCOD_OP_DEC_SP = 6'h2d,
    MCOD_OP_FREE = 6'h2e,
    MCOD_OP_NOP = 6'h2f
  } mcod_op_t;

endpackage : mcod_pkg
